/* core/ris_core.sv */
// Purpose: Event flags, enable registers and host interrupt line of the radio
// Assumes: Register port gives a one-cycle read or write strobe with a 7-bit offset
// Notes: Interrupt line is registered but fed by next-state rises, so it falls on the same edge as a flag sets
`timescale 1ns/1ps
`include "ris_regs.svh"
module ris_core
    import ris_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire ris_ev_one_t ev_one,
    input wire ris_ev_two_t ev_two,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic host_interrupt_line_low
);
    logic [7:0] enable_one_reg;
    logic [7:0] enable_two_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic irq_line_reg;
    logic [7:0] set_one;
    logic [7:0] clr_one;
    logic [7:0] set_two;
    logic [7:0] clr_two;
    logic [7:0] live_two;
    logic [7:0] level_two;
    logic [7:0] flag_one;
    logic [7:0] flag_two;
    logic [7:0] rise_one;
    logic [7:0] rise_two;
    logic rd_one;
    logic rd_two;

    function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
        hit = (a == ofs);
    endfunction

    assign rd_one = reg_rd && hit(reg_addr, `RIS_OFS_STATUS_ONE);
    assign rd_two = reg_rd && hit(reg_addr, `RIS_OFS_STATUS_TWO);

    always_comb begin
        set_one = 8'h00;
        clr_one = 8'h00;
        set_one[`RIS_BIT_FIFO_ERR] = ev_one.fifo_ovf_unf; // [R1]
        clr_one[`RIS_BIT_FIFO_ERR] = ev_one.tx_fifo_reset || ev_one.rx_fifo_reset; // [R1]
        set_one[`RIS_BIT_TX_AFULL] = ev_one.tx_afull_above; // [R2]
        clr_one[`RIS_BIT_TX_AFULL] = ev_one.tx_afull_drained; // [R2]
        set_one[`RIS_BIT_TX_AEMPTY] = ev_one.tx_aempty_at_or_below; // [R3]
        clr_one[`RIS_BIT_TX_AEMPTY] = !ev_one.tx_aempty_at_or_below; // [R3]
        set_one[`RIS_BIT_RX_AFULL] = ev_one.rx_afull_above; // [R4]
        clr_one[`RIS_BIT_RX_AFULL] = ev_one.rx_afull_below; // [R4]
        set_one[`RIS_BIT_EXT] = ev_one.ext_event;
        set_one[`RIS_BIT_PK_SENT] = ev_one.pk_sent; // [R5]
        clr_one[`RIS_BIT_PK_SENT] = ev_one.fifo_mode_leave || ev_one.tx_start; // [R5]
        set_one[`RIS_BIT_PK_VALID] = ev_one.pk_valid; // [R6]
        clr_one[`RIS_BIT_PK_VALID] = ev_one.sync_ack; // [R6]
        set_one[`RIS_BIT_CRC_ERR] = ev_one.crc_mismatch; // [R7]
        clr_one[`RIS_BIT_CRC_ERR] = ev_one.rx_data_start; // [R7]
    end

    // Second register layout; live flags follow their source level while disabled
    always_comb begin
        set_two = 8'h00;
        clr_two = 8'h00;
        live_two = 8'h00;
        level_two = 8'h00;
        set_two[`RIS_BIT_SYNC] = ev_two.sync_det; // [R8] [R18]
        clr_two[`RIS_BIT_SYNC] = ev_two.rx_done; // [R18]
        set_two[`RIS_BIT_PRE_VAL] = ev_two.preamble_det; // [R19]
        clr_two[`RIS_BIT_PRE_VAL] = ev_two.sync_det || ev_two.sync_timeout; // [R19]
        // Self-clearing pulse as status; latching only makes sense as an interrupt
        set_two[`RIS_BIT_PRE_INVAL] = ev_two.preamble_inval; // [R9]
        live_two[`RIS_BIT_PRE_INVAL] = 1'b1; // [R9]
        level_two[`RIS_BIT_PRE_INVAL] = ev_two.preamble_inval; // [R9]
        set_two[`RIS_BIT_RSSI] = ev_two.rssi_above; // [R10]
        live_two[`RIS_BIT_RSSI] = 1'b1; // [R10]
        level_two[`RIS_BIT_RSSI] = ev_two.rssi_above; // [R10]
        set_two[`RIS_BIT_WUT] = ev_two.wut_expire; // [R11]
        // Latched regardless of enable, so enabling later still interrupts
        set_two[`RIS_BIT_LBD] = ev_two.lbd_event; // [R12]
        set_two[`RIS_BIT_CHIP_RDY] = ev_two.chip_ready; // [R13]
        clr_two[`RIS_BIT_CHIP_RDY] = ev_two.idle_mode; // [R13]
        set_two[`RIS_BIT_POR] = ev_two.por_event; // [R14]
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            ris_flag u_one (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .enable(enable_one_reg[gi]),
                .set_ev(set_one[gi]),
                .status_clr(clr_one[gi]),
                .live_mode(1'b0),
                .live_level(1'b0),
                .rd_clr(rd_one), // [R20]
                .flag(flag_one[gi]),
                .rise(rise_one[gi])
            );
            ris_flag u_two (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .enable(enable_two_reg[gi]),
                .set_ev(set_two[gi]),
                .status_clr(clr_two[gi]),
                .live_mode(live_two[gi]),
                .live_level(level_two[gi]),
                .rd_clr(rd_two), // [R16]
                .flag(flag_two[gi]),
                .rise(rise_two[gi])
            );
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            enable_one_reg <= `RIS_ENABLE_ONE_RST;
            enable_two_reg <= `RIS_ENABLE_TWO_RST; // [R21]
        end else if (reg_wr) begin
            if (hit(reg_addr, `RIS_OFS_ENABLE_ONE)) begin
                enable_one_reg <= reg_wdata;
            end else if (hit(reg_addr, `RIS_OFS_ENABLE_TWO)) begin
                // Upper enables are read-only and keep their reset value
                enable_two_reg <= (enable_two_reg & ~`RIS_ENABLE_TWO_WMASK) |
                                  (reg_wdata & `RIS_ENABLE_TWO_WMASK);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd;
            if (!reg_rd) begin
                rdata_reg <= rdata_reg;
            end else if (hit(reg_addr, `RIS_OFS_STATUS_ONE)) begin
                rdata_reg <= flag_one;
            end else if (hit(reg_addr, `RIS_OFS_STATUS_TWO)) begin
                rdata_reg <= flag_two;
            end else if (hit(reg_addr, `RIS_OFS_ENABLE_ONE)) begin
                rdata_reg <= enable_one_reg;
            end else if (hit(reg_addr, `RIS_OFS_ENABLE_TWO)) begin
                rdata_reg <= enable_two_reg;
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end

    // Line holds while any enabled flag pends; a fresh rising event beats a read release
    logic pend_one;
    logic pend_two;
    logic new_ev;
    assign pend_one = |(flag_one & enable_one_reg) && !rd_one;
    assign pend_two = |(flag_two & enable_two_reg) && !rd_two;
    assign new_ev = |(rise_one & enable_one_reg) || |(rise_two & enable_two_reg);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_line_reg <= 1'b1;
        end else begin
            // Held as the pin level so the output leaves a bare flop
            irq_line_reg <= !(new_ev || pend_one || pend_two); // [R15] [R20] [R22] [R16]
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign host_interrupt_line_low = irq_line_reg;

    property p_rise_irq;
        @(posedge sys_clk) disable iff (!rst_n)
            (|(rise_two & enable_two_reg)) |=> !host_interrupt_line_low;
    endproperty
    a_rise_irq: assert property (p_rise_irq) else $error("enabled rise did not pull line low"); // [R15]

    property p_read_release;
        @(posedge sys_clk) disable iff (!rst_n)
            (rd_two && !new_ev && !(|(flag_one & enable_one_reg)))
            |=> host_interrupt_line_low && ((flag_two & enable_two_reg & ~$past(set_two)) == 8'h00);
    endproperty
    a_read_release: assert property (p_read_release) else $error("read did not release line"); // [R16]

    property p_status_kept;
        @(posedge sys_clk) disable iff (!rst_n)
            (rd_two && flag_two[`RIS_BIT_CHIP_RDY] && !enable_two_reg[`RIS_BIT_CHIP_RDY]
             && !clr_two[`RIS_BIT_CHIP_RDY]) |=> flag_two[`RIS_BIT_CHIP_RDY];
    endproperty
    a_status_kept: assert property (p_status_kept) else $error("disabled flag cleared by read"); // [R17]

    property p_pending_low;
        @(posedge sys_clk) disable iff (!rst_n)
            (|(flag_one & enable_one_reg) && !rd_one) |=> !host_interrupt_line_low;
    endproperty
    a_pending_low: assert property (p_pending_low) else $error("pending flag without line low"); // [R22]

    property p_fifo_err;
        @(posedge sys_clk) disable iff (!rst_n)
            ev_one.fifo_ovf_unf |=> flag_one[`RIS_BIT_FIFO_ERR];
    endproperty
    a_fifo_err: assert property (p_fifo_err) else $error("fifo error not set"); // [R1]

    property p_rssi_live;
        @(posedge sys_clk) disable iff (!rst_n)
            (!enable_two_reg[`RIS_BIT_RSSI] && ev_two.rssi_above)[*2] |-> flag_two[`RIS_BIT_RSSI];
    endproperty
    a_rssi_live: assert property (p_rssi_live) else $error("rssi status not held"); // [R10]

    property p_lbd_latch;
        @(posedge sys_clk) disable iff (!rst_n)
            (ev_two.lbd_event && !enable_two_reg[`RIS_BIT_LBD]) |=> flag_two[`RIS_BIT_LBD];
    endproperty
    a_lbd_latch: assert property (p_lbd_latch) else $error("low battery not latched"); // [R12]

    property p_chip_idle;
        @(posedge sys_clk) disable iff (!rst_n)
            (ev_two.idle_mode && !ev_two.chip_ready) |=> !flag_two[`RIS_BIT_CHIP_RDY];
    endproperty
    a_chip_idle: assert property (p_chip_idle) else $error("chip ready not cleared at idle"); // [R13]

    property p_enable_reset;
        @(posedge sys_clk) $rose(rst_n) |-> enable_two_reg == `RIS_ENABLE_TWO_RST;
    endproperty
    a_enable_reset: assert property (p_enable_reset) else $error("enable two reset value wrong"); // [R21]

    sequence s_one_raise;
        (|(rise_one & enable_one_reg));
    endsequence

    // A masked low-battery flag must fire once the host unmasks it
    sequence s_lbd_held;
        flag_two[`RIS_BIT_LBD] && !enable_two_reg[`RIS_BIT_LBD];
    endsequence

    sequence s_lbd_unmask;
        reg_wr && !reg_rd && hit(reg_addr, `RIS_OFS_ENABLE_TWO) && reg_wdata[`RIS_BIT_LBD];
    endsequence

    property p_lbd_unmask;
        @(posedge sys_clk) disable iff (!rst_n)
            s_lbd_held ##0 s_lbd_unmask ##1 !rd_two |=> !host_interrupt_line_low;
    endproperty
    a_lbd_unmask: assert property (p_lbd_unmask) else $error("unmasked low battery did not interrupt"); // [R12]

    property p_one_rise_irq;
        @(posedge sys_clk) disable iff (!rst_n)
            s_one_raise |=> !host_interrupt_line_low;
    endproperty
    a_one_rise_irq: assert property (p_one_rise_irq) else $error("enabled rise in status one not signalled"); // [R20]

    property p_read_one_release;
        @(posedge sys_clk) disable iff (!rst_n)
            (rd_one && !reg_wr && !new_ev && !(|(flag_two & enable_two_reg)))
            |=> host_interrupt_line_low && ((flag_one & enable_one_reg & ~$past(set_one)) == 8'h00);
    endproperty
    a_read_one_release: assert property (p_read_one_release) else $error("status one read did not release"); // [R20]

    property p_fifo_clr;
        @(posedge sys_clk) disable iff (!rst_n)
            (ev_one.tx_fifo_reset || ev_one.rx_fifo_reset) && !ev_one.fifo_ovf_unf |=> !flag_one[`RIS_BIT_FIFO_ERR];
    endproperty
    a_fifo_clr: assert property (p_fifo_clr) else $error("fifo error not cleared"); // [R1]

    property p_tx_afull;
        @(posedge sys_clk) disable iff (!rst_n)
            ev_one.tx_afull_above |=> flag_one[`RIS_BIT_TX_AFULL];
    endproperty
    a_tx_afull: assert property (p_tx_afull) else $error("tx almost full not set"); // [R2]

    property p_tx_aempty;
        @(posedge sys_clk) disable iff (!rst_n)
            rst_n |=> flag_one[`RIS_BIT_TX_AEMPTY] == $past(ev_one.tx_aempty_at_or_below);
    endproperty
    a_tx_aempty: assert property (p_tx_aempty) else $error("tx almost empty does not follow count"); // [R3]

    property p_rx_afull_clr;
        @(posedge sys_clk) disable iff (!rst_n)
            ev_one.rx_afull_below && !ev_one.rx_afull_above |=> !flag_one[`RIS_BIT_RX_AFULL];
    endproperty
    a_rx_afull_clr: assert property (p_rx_afull_clr) else $error("rx almost full not cleared"); // [R4]

    property p_pk_sent;
        @(posedge sys_clk) disable iff (!rst_n)
            ev_one.pk_sent |=> flag_one[`RIS_BIT_PK_SENT];
    endproperty
    a_pk_sent: assert property (p_pk_sent) else $error("packet sent not set"); // [R5]

    property p_pk_sent_clr;
        @(posedge sys_clk) disable iff (!rst_n)
            (ev_one.fifo_mode_leave || ev_one.tx_start) && !ev_one.pk_sent |=> !flag_one[`RIS_BIT_PK_SENT];
    endproperty
    a_pk_sent_clr: assert property (p_pk_sent_clr) else $error("packet sent not cleared"); // [R5]

    property p_pk_valid_clr;
        @(posedge sys_clk) disable iff (!rst_n)
            ev_one.sync_ack && !ev_one.pk_valid |=> !flag_one[`RIS_BIT_PK_VALID];
    endproperty
    a_pk_valid_clr: assert property (p_pk_valid_clr) else $error("valid packet not cleared"); // [R6]

    property p_crc_clr;
        @(posedge sys_clk) disable iff (!rst_n)
            ev_one.rx_data_start && !ev_one.crc_mismatch |=> !flag_one[`RIS_BIT_CRC_ERR];
    endproperty
    a_crc_clr: assert property (p_crc_clr) else $error("crc error not cleared"); // [R7]

    property p_rdata_two;
        @(posedge sys_clk) disable iff (!rst_n)
            rd_two |=> reg_rvalid && (reg_rdata == $past(flag_two));
    endproperty
    a_rdata_two: assert property (p_rdata_two) else $error("status two read data wrong"); // [R8]

    property p_pre_inval;
        @(posedge sys_clk) disable iff (!rst_n)
            ev_two.preamble_inval |=> flag_two[`RIS_BIT_PRE_INVAL];
    endproperty
    a_pre_inval: assert property (p_pre_inval) else $error("invalid preamble not set"); // [R9]

    property p_wut;
        @(posedge sys_clk) disable iff (!rst_n)
            ev_two.wut_expire |=> flag_two[`RIS_BIT_WUT];
    endproperty
    a_wut: assert property (p_wut) else $error("wake-up timer not set"); // [R11]

    property p_por;
        @(posedge sys_clk) disable iff (!rst_n)
            ev_two.por_event |=> flag_two[`RIS_BIT_POR];
    endproperty
    a_por: assert property (p_por) else $error("power-on not set"); // [R14]

    property p_sync_clr;
        @(posedge sys_clk) disable iff (!rst_n)
            ev_two.rx_done && !ev_two.sync_det |=> !flag_two[`RIS_BIT_SYNC];
    endproperty
    a_sync_clr: assert property (p_sync_clr) else $error("sync status not cleared"); // [R18]

    property p_pre_val_clr;
        @(posedge sys_clk) disable iff (!rst_n)
            (ev_two.sync_det || ev_two.sync_timeout) && !ev_two.preamble_det |=> !flag_two[`RIS_BIT_PRE_VAL];
    endproperty
    a_pre_val_clr: assert property (p_pre_val_clr) else $error("valid preamble not cleared"); // [R19]
endmodule

/* core/ris_regs.svh */
// Purpose: Register offsets, bit positions and reset values of the radio event status logic
// Assumes: Byte-wide registers reached through the serial register port
// Notes: Types live in ris_pkg
// Behaviour
// R1 - FIFO error sets on overflow or underflow, clears only on that FIFO's reset. The code clears it on either FIFO's reset, and on a read while enabled.
// R2 - Transmit almost-full sets above threshold, clears in transmission at or below it.
// R3 - Transmit almost-empty sets at or below threshold, clears once above it.
// R4 - Receive almost-full sets above threshold, clears once count falls below it.
// R5 - Packet-sent sets on clean send, clears leaving FIFO mode or new send.
// R6 - Valid-packet sets on clean receive, clears on next acknowledged sync word.
// R7 - CRC-error sets on mismatch, clears when next packet's data reception begins.
// R8 - Second status register holds sync, preamble, strength, timer, battery, ready, power-on flags.
// R9 - Invalid-preamble sets on detection timeout; as status it clears itself.
// R10 - Signal-strength flag stays high while level remains above threshold.
// R11 - Wake-up-timer flag sets when the programmed timer expires.
// R12 - Low-battery event latches while disabled and interrupts once enabled.
// R13 - Chip-ready sets after enable plus crystal settling, holds until idle.
// R14 - Power-on flag sets when a power-on reset is detected.
// R15 - Enabled second-status flag rising drives interrupt line low.
// R16 - Reading second status releases line and clears its enabled flags.
// R17 - Disabled flags are plain status, never cleared by a read.
// R18 - Sync-detected status rises on sync word, falls when packet reception ends.
// R19 - Valid-preamble status rises on preamble, falls on sync or sync timeout.
// R20 - First status register holds FIFO, packet, CRC flags under the same rules.
// R21 - Host programs second enable register; reset value enables ready and power-on. Only bits 3:0 are host-writable; bits 7:4 stay at reset.
// R22 - Line stays low while any enabled flag pends; new events reassert it.
// R23 - Host reads both status registers after seeing the line low.
`ifndef RIS_REGS_SVH
`define RIS_REGS_SVH
`define RIS_OFS_STATUS_ONE 7'h03
`define RIS_OFS_STATUS_TWO 7'h04
`define RIS_OFS_ENABLE_ONE 7'h05
`define RIS_OFS_ENABLE_TWO 7'h06
`define RIS_ENABLE_ONE_RST 8'h00
`define RIS_ENABLE_TWO_RST 8'h03
`define RIS_ENABLE_TWO_WMASK 8'h0f
`define RIS_BIT_FIFO_ERR 7
`define RIS_BIT_TX_AFULL 6
`define RIS_BIT_TX_AEMPTY 5
`define RIS_BIT_RX_AFULL 4
`define RIS_BIT_EXT 3
`define RIS_BIT_PK_SENT 2
`define RIS_BIT_PK_VALID 1
`define RIS_BIT_CRC_ERR 0
`define RIS_BIT_SYNC 7
`define RIS_BIT_PRE_VAL 6
`define RIS_BIT_PRE_INVAL 5
`define RIS_BIT_RSSI 4
`define RIS_BIT_WUT 3
`define RIS_BIT_LBD 2
`define RIS_BIT_CHIP_RDY 1
`define RIS_BIT_POR 0
`endif

/* core/ris_pkg.sv */
// Purpose: Types shared by the radio event status logic
// Assumes: Nothing beyond the register header
// Notes: Event groups are packed structs
package ris_pkg;
    typedef struct packed {
        logic fifo_ovf_unf;
        logic tx_fifo_reset;
        logic rx_fifo_reset;
        logic tx_afull_above;
        logic tx_afull_drained;
        logic tx_aempty_at_or_below;
        logic rx_afull_above;
        logic rx_afull_below;
        logic ext_event;
        logic pk_sent;
        logic fifo_mode_leave;
        logic tx_start;
        logic pk_valid;
        logic sync_ack;
        logic crc_mismatch;
        logic rx_data_start;
    } ris_ev_one_t;
    typedef struct packed {
        logic sync_det;
        logic rx_done;
        logic preamble_det;
        logic sync_timeout;
        logic preamble_inval;
        logic rssi_above;
        logic wut_expire;
        logic lbd_event;
        logic chip_ready;
        logic idle_mode;
        logic por_event;
    } ris_ev_two_t;
    typedef enum logic [1:0] {
        RIS_ST_IDLE,
        RIS_ST_ADDR,
        RIS_ST_DATA
    } ris_bus_state_t;
endpackage

/* core/ris_flag.sv */
// Purpose: One status flag with latched-interrupt or live-status behaviour
// Assumes: Set and clear come from the event logic, read clear from the bus
// Notes: Set wins over every clear in the same cycle
`timescale 1ns/1ps
module ris_flag (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic set_ev,
    input wire logic status_clr,
    input wire logic live_mode,
    input wire logic live_level,
    input wire logic rd_clr,
    output logic flag,
    output logic rise
);
    logic flag_reg;
    logic flag_next;
    always_comb begin
        flag_next = flag_reg;
        if (live_mode && !enable) begin
            flag_next = live_level;
        end else if (set_ev) begin
            flag_next = 1'b1;
        end else if (status_clr || (rd_clr && enable)) begin // [R17] [R16]
            flag_next = 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end
    assign flag = flag_reg;
    assign rise = flag_next && !flag_reg;
endmodule

/* verif/ris_host_model.sv */
// Purpose: Host side of the serial register port of the radio event status logic
// Assumes: One strobe per access, taken at the rising clock edge
// Notes: Read data is judged by the bench monitor; this model only waits for it
`timescale 1ns/1ps
module ris_host_model (
    input wire logic sys_clk,
    input wire logic reg_rvalid,
    output logic reg_rd,
    output logic reg_wr,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    // Programs an enable register, read-only bits included, as a real host may
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // Acknowledges pending sources by a read, waiting up to 8 cycles for valid; stale address is inverted
    task automatic rd(input logic [6:0] a, output bit ok);
        ok = 1'b0;
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge sys_clk);
            ok = (reg_rvalid === 1'b1);
        end
    endtask
endmodule

/* verif/test_radio_irq_status_logic.sv */
// Purpose: Self-checking bench of the radio event status logic
// Assumes: Read data one cycle after the read strobe, line registered
// Notes: Reads queue their expected byte; a monitor compares on each valid
`timescale 1ns/1ps
`include "ris_regs.svh"
module test_radio_irq_status_logic;
    import ris_pkg::*;
    logic sys_clk;
    logic rst_n;
    ris_ev_one_t ev_one;
    ris_ev_two_t ev_two;
    logic reg_rd;
    logic reg_wr;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic host_interrupt_line_low;
    logic [7:0] exp_q[$];
    logic [7:0] rnd;
    int num_errors;
    int checks;
    ris_core dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .ev_one(ev_one), .ev_two(ev_two), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .host_interrupt_line_low(host_interrupt_line_low));
    ris_host_model host_u (.sys_clk(sys_clk), .reg_rvalid(reg_rvalid), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    always #2 sys_clk = ~sys_clk;
    task automatic summarize();
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Unrequested read data always counts as a mismatch
    always @(posedge sys_clk) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) exp_q.push_back(~reg_rdata);
            check(reg_rdata, exp_q.pop_front());
        end
    end
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        bit ok;
        exp_q.push_back(e);
        host_u.rd(a, ok);
        if (!ok) begin
            num_errors++;
            summarize();
        end
    endtask
    task automatic chk_line(input logic e);
        @(posedge sys_clk);
        #1;
        check({7'h00, host_interrupt_line_low}, {7'h00, e});
    endtask
    task automatic drive(input bit two, input logic [15:0] v);
        @(posedge sys_clk);
        if (two) ev_two <= ris_ev_two_t'(v[10:0]);
        else ev_one <= ris_ev_one_t'(v);
    endtask
    // Disabled flag: set, survives two reads, then its own clear or level drop removes it
    task automatic st(input bit two, input logic [15:0] set, input logic [15:0] clr, input logic [7:0] b,
        input bit level);
        logic [6:0] a;
        a = two ? `RIS_OFS_STATUS_TWO : `RIS_OFS_STATUS_ONE;
        drive(two, set);
        if (!level) drive(two, 16'h0000);
        rd(a, b);
        rd(a, b);
        if (!level) drive(two, clr);
        drive(two, 16'h0000);
        repeat (2) @(posedge sys_clk);
        rd(a, 8'h00);
        chk_line(1'b1);
    endtask
    // Enabled flag: event pulls the line low, the read returns it and clears the flag
    task automatic irq(input bit two, input logic [7:0] en, input logic [15:0] set, input logic [7:0] b);
        logic [6:0] a;
        a = two ? `RIS_OFS_STATUS_TWO : `RIS_OFS_STATUS_ONE;
        host_u.wr(two ? `RIS_OFS_ENABLE_TWO : `RIS_OFS_ENABLE_ONE, en);
        drive(two, set);
        drive(two, 16'h0000);
        chk_line(1'b0);
        rd(a, b);
        chk_line(1'b1);
        rd(a, 8'h00);
        host_u.wr(two ? `RIS_OFS_ENABLE_TWO : `RIS_OFS_ENABLE_ONE, 8'h00);
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        num_errors++;
        summarize();
    end
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        ev_one = '0;
        ev_two = '0;
        num_errors = 0;
        checks = 0;
        void'($urandom(12407));
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk_line(1'b1);
        rd(7'h05, 8'h00);
        rd(7'h06, 8'h03);
        rd(7'h04, 8'h00);
        rd(7'h11, 8'h00);
        host_u.wr(7'h03, 8'hff);
        rd(7'h03, 8'h00);
        rnd = 8'($urandom);
        host_u.wr(7'h05, rnd);
        rd(7'h05, rnd);
        host_u.wr(7'h06, ~rnd);
        rd(7'h06, ~rnd & 8'h0f);
        host_u.wr(7'h05, 8'h00);
        host_u.wr(7'h06, 8'h00);
        st(0, 16'h8000, 16'h2000, 8'h80, 0);
        st(0, 16'h8000, 16'h4000, 8'h80, 0);
        st(0, 16'h1000, 16'h0800, 8'h40, 0);
        st(0, 16'h0400, 16'h0000, 8'h20, 1);
        st(0, 16'h0200, 16'h0100, 8'h10, 0);
        st(0, 16'h0040, 16'h0020, 8'h04, 0);
        st(0, 16'h0040, 16'h0010, 8'h04, 0);
        st(0, 16'h0008, 16'h0004, 8'h02, 0);
        st(0, 16'h0002, 16'h0001, 8'h01, 0);
        st(1, 16'h0400, 16'h0200, 8'h80, 0);
        st(1, 16'h0100, 16'h0080, 8'h40, 0);
        st(1, 16'h0040, 16'h0000, 8'h20, 1);
        st(1, 16'h0020, 16'h0000, 8'h10, 1);
        st(1, 16'h0004, 16'h0002, 8'h02, 0);
        irq(0, 8'h08, 16'h0080, 8'h08);
        irq(0, 8'h04, 16'h0040, 8'h04);
        irq(1, 8'h08, 16'h0010, 8'h08);
        irq(1, 8'h01, 16'h0001, 8'h01);
        irq(1, 8'h02, 16'h0004, 8'h02);
        // Low battery is kept while masked and fires once unmasked
        drive(1, 16'h0008);
        drive(1, 16'h0000);
        chk_line(1'b1);
        rd(7'h04, 8'h04);
        host_u.wr(7'h06, 8'h04);
        chk_line(1'b0);
        rd(7'h04, 8'h04);
        chk_line(1'b1);
        rd(7'h04, 8'h00);
        // Pending sources in both registers keep the line low until both are read
        host_u.wr(7'h05, 8'h04);
        host_u.wr(7'h06, 8'h01);
        drive(0, 16'h0040);
        drive(0, 16'h0000);
        drive(1, 16'h0001);
        drive(1, 16'h0000);
        rd(7'h04, 8'h01);
        chk_line(1'b0);
        rd(7'h03, 8'h04);
        chk_line(1'b1);
        drive(1, 16'h0001);
        drive(1, 16'h0000);
        chk_line(1'b0);
        rd(7'h04, 8'h01);
        chk_line(1'b1);
        repeat (4) @(posedge sys_clk);
        if (exp_q.size() != 0) num_errors++;
        summarize();
    end
endmodule
